// ### include/nor_cmd_map.svh
// Purpose: command codes, configuration defaults and field positions
// Assumes: 16-bit data bus, word address on A[26:1]
// Notes:   included by the command controller and the testbench
`ifndef NOR_CMD_MAP_SVH
`define NOR_CMD_MAP_SVH

`define CMD_READ_ARRAY    8'hff
`define CMD_READ_ID       8'h90
`define CMD_READ_QUERY    8'h98
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_WORD_PROG     8'h40
`define CMD_BUF_PROG      8'he8
`define CMD_FACTORY_PROG  8'h80
`define CMD_ERASE         8'h20
`define CMD_BLANK_CHECK   8'hbc
`define CMD_SUSPEND       8'hb0
`define CMD_CONFIRM       8'hd0
`define CMD_LOCK_SETUP    8'h60
`define CMD_LOCK          8'h01
`define CMD_LOCK_DOWN     8'h2f
`define CMD_SET_CONFIG    8'h03
`define CMD_OTP_PROG      8'hc0
`define CMD_EXT_FUNC      8'heb

`define BUF_MAX_WORDS     10'd512
`define RCFG_RESET        16'h8000
`define RCFG_ASYNC_BIT    15
`define RCFG_WAIT_POL_BIT 10
`define ADDR_MSB          26
`define CFG_MSB           16
`define CFG_LSB           1
`define PAGE_MSB          4
`define PAGE_LSB          1

`endif

// ### include/nor_cmd_pkg.sv
// Purpose: types shared by the command controller and its users
// Assumes: nothing beyond the map header
// Notes:   binary codes written out
package nor_cmd_pkg;
   typedef enum logic [1:0] {
      RD_ARRAY  = 2'b00,
      RD_ID     = 2'b01,
      RD_STATUS = 2'b10,
      RD_QUERY  = 2'b11
   } rd_state_t;

   typedef enum logic [3:0] {
      DEC_IDLE = 4'h0, DEC_SETUP2 = 4'h1, DEC_BUF_COUNT = 4'h2, DEC_BUF_DATA = 4'h3,
      DEC_BUF_CONFIRM = 4'h4, DEC_FBP_CONFIRM = 4'h5, DEC_FBP_DATA = 4'h6,
      DEC_EFI_SUB = 4'h7, DEC_EFI_COUNT = 4'h8, DEC_EFI_DATA = 4'h9,
      DEC_EFI_CONFIRM = 4'ha
   } dec_state_t;

   typedef enum logic [3:0] {
      OP_WORD_PROG = 4'h0, OP_BUF_DATA = 4'h1, OP_BUF_PROG = 4'h2, OP_FACTORY = 4'h3,
      OP_FACT_DATA = 4'h4, OP_ERASE = 4'h5, OP_BLANK = 4'h6, OP_LOCK = 4'h7,
      OP_UNLOCK = 4'h8, OP_LOCK_DOWN = 4'h9, OP_OTP = 4'ha, OP_EFI_DATA = 4'hb,
      OP_EFI = 4'hc, OP_SUSPEND = 4'hd, OP_RESUME = 4'he
   } op_t;
endpackage

// ### src/nor_cmd_ctrl.sv
// Purpose: command decoder and asynchronous read-mode control of a NOR flash
// Assumes: one write per accepted cycle; reads are a one-cycle request
// Notes:   operations leave through a two-entry buffer to the algorithm engine
`include "nor_cmd_map.svh"
`timescale 1ns/1ns
`default_nettype none
module nor_cmd_ctrl (
   // clock and reset
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_i,
   // write bus
   input  wire logic                        wr_valid_i,
   input  wire logic [`ADDR_MSB:1]          wr_addr_i,
   input  wire logic [15:0]                 wr_data_i,
   output logic                             wr_ready_o,
   // operation stream to the algorithm engine
   output logic                             op_valid_o,
   input  wire logic                        op_ready_i,
   output nor_cmd_pkg::op_t                 op_code_o,
   output logic [`ADDR_MSB:1]               op_addr_o,
   output logic [15:0]                      op_data_o,
   input  wire logic                        op_done_i,
   // read side
   input  wire logic                        rd_req_i,
   input  wire logic [`ADDR_MSB:1]          rd_addr_i,
   input  wire logic                        address_valid_pin_n_i,
   output logic                             sense_o,
   output logic [`ADDR_MSB:1]               sense_addr_o,
   output logic [3:0]                       word_sel_o,
   output logic                             wait_o,
   // state
   output nor_cmd_pkg::rd_state_t           read_state_o,
   output logic [15:0]                      read_cfg_o,
   output logic                             page_mode_o,
   output logic                             busy_o,
   output logic                             suspended_o,
   output logic                             status_program_fail_bit_o,
   output logic                             status_erase_fail_bit_o
);
   import nor_cmd_pkg::*;

   dec_state_t              st_r, st_nxt;
   logic [7:0]              cmd_r;
   logic [`ADDR_MSB:1]      cmd_addr_r;
   logic [15:0]             sub_r;
   logic [9:0]              words_r, words_nxt, total_r;
   logic                    acc;
   logic                    push, seq_err, start_op, set_cfg;
   op_t                     push_code;
   logic [15:0]             push_data;
   logic                    rd_set;
   rd_state_t               rd_val;
   logic [7:0]              wd;
   logic [1:0]              cnt_r, cnt_nxt;
   logic                    pop;
   op_t                     mem_code [2];
   logic [`ADDR_MSB:1]      mem_addr [2];
   logic [15:0]             mem_data [2];
   logic                    slot;
   logic [`ADDR_MSB:1]      addr_hold_r, rd_addr_eff;
   logic [`ADDR_MSB:5]      page_base_r;
   logic                    page_ok_r;
   logic                    page_hit;
   localparam logic [15:0]  RCFG_DEFAULT = `RCFG_RESET;

   function automatic logic is_count(input logic [15:0] d);
      is_count = d < {6'h00, `BUF_MAX_WORDS};
   endfunction

   assign acc = wr_valid_i && wr_ready_o;
   assign wd  = wr_data_i[7:0];
   assign pop = op_valid_o && op_ready_i;

   // decoder: one write at a time, commands only outside data phases
   always_comb begin
      st_nxt    = st_r;
      words_nxt = words_r;
      push      = 1'b0;
      push_code = OP_WORD_PROG;
      push_data = wr_data_i;
      seq_err   = 1'b0;
      start_op  = 1'b0;
      set_cfg   = 1'b0;
      rd_set    = 1'b0;
      rd_val    = RD_STATUS;
      if (acc) begin
         unique case (st_r)
            DEC_IDLE: begin
               unique case (wd)
                  `CMD_READ_ARRAY:  begin rd_set = 1'b1; rd_val = RD_ARRAY; end
                  `CMD_READ_ID:     begin rd_set = 1'b1; rd_val = RD_ID; end
                  `CMD_READ_QUERY:  begin rd_set = 1'b1; rd_val = RD_QUERY; end
                  `CMD_READ_STATUS: rd_set = 1'b1;
                  `CMD_CLEAR_STATUS: ;
                  `CMD_SUSPEND: if (busy_o && !suspended_o) begin
                     push = 1'b1;
                     push_code = OP_SUSPEND;
                  end
                  `CMD_CONFIRM: if (suspended_o) begin
                     push = 1'b1;
                     push_code = OP_RESUME;
                  end
                  `CMD_BUF_PROG: begin
                     st_nxt = DEC_BUF_COUNT;
                     rd_set = 1'b1;
                  end
                  `CMD_FACTORY_PROG: st_nxt = DEC_FBP_CONFIRM;
                  `CMD_EXT_FUNC: st_nxt = DEC_EFI_SUB;
                  `CMD_WORD_PROG, `CMD_ERASE, `CMD_BLANK_CHECK, `CMD_LOCK_SETUP,
                  `CMD_OTP_PROG: st_nxt = DEC_SETUP2;
                  default: ;
               endcase
            end
            DEC_SETUP2: begin
               st_nxt = DEC_IDLE;
               push   = 1'b1;
               unique case (cmd_r)
                  `CMD_WORD_PROG: push_code = OP_WORD_PROG;
                  `CMD_OTP_PROG:  push_code = OP_OTP;
                  `CMD_ERASE: begin
                     push_code = OP_ERASE;
                     push = wd == `CMD_CONFIRM;
                  end
                  `CMD_BLANK_CHECK: begin
                     push_code = OP_BLANK;
                     push = wd == `CMD_CONFIRM;
                  end
                  default: begin
                     push = wd == `CMD_LOCK || wd == `CMD_CONFIRM || wd == `CMD_LOCK_DOWN;
                     push_code = wd == `CMD_LOCK ? OP_LOCK :
                                 wd == `CMD_LOCK_DOWN ? OP_LOCK_DOWN : OP_UNLOCK;
                     set_cfg = wd == `CMD_SET_CONFIG;
                  end
               endcase
               seq_err = !push && !set_cfg;
               if (set_cfg) begin
                  rd_set = 1'b1;
                  rd_val = RD_ARRAY;
               end
            end
            DEC_BUF_COUNT, DEC_EFI_COUNT: begin
               words_nxt = '0;
               if (is_count(wr_data_i))
                  st_nxt = st_r == DEC_BUF_COUNT ? DEC_BUF_DATA : DEC_EFI_DATA;
               else begin
                  seq_err = 1'b1;
                  st_nxt  = DEC_IDLE;
               end
            end
            DEC_BUF_DATA, DEC_EFI_DATA: begin
               push      = 1'b1;
               push_code = st_r == DEC_BUF_DATA ? OP_BUF_DATA : OP_EFI_DATA;
               words_nxt = words_r + 10'd1;
               if (words_r == total_r)
                  st_nxt = st_r == DEC_BUF_DATA ? DEC_BUF_CONFIRM : DEC_EFI_CONFIRM;
            end
            DEC_BUF_CONFIRM, DEC_EFI_CONFIRM, DEC_FBP_CONFIRM: begin
               push      = wd == `CMD_CONFIRM;
               seq_err   = !push;
               push_code = st_r == DEC_BUF_CONFIRM ? OP_BUF_PROG :
                           st_r == DEC_EFI_CONFIRM ? OP_EFI : OP_FACTORY;
               push_data = st_r == DEC_EFI_CONFIRM ? sub_r : wr_data_i;
               st_nxt    = push && st_r == DEC_FBP_CONFIRM ? DEC_FBP_DATA : DEC_IDLE;
            end
            DEC_FBP_DATA: begin
               push      = 1'b1;
               push_code = OP_FACT_DATA;
            end
            DEC_EFI_SUB: st_nxt = DEC_EFI_COUNT;
            default: st_nxt = DEC_IDLE;
         endcase
      end
      if (st_r == DEC_FBP_DATA && op_done_i && !acc)
         st_nxt = DEC_IDLE;
      if (seq_err)
         rd_set = 1'b1;
      start_op = push && push_code != OP_SUSPEND && push_code != OP_RESUME
                 && push_code != OP_BUF_DATA && push_code != OP_EFI_DATA
                 && push_code != OP_FACT_DATA;
      if (start_op)
         rd_set = 1'b1;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_r    <= DEC_IDLE;
         cmd_r   <= 8'h00;
         words_r <= 10'd0;
      end else begin
         st_r    <= st_nxt;
         words_r <= words_nxt;
         if (acc && st_r == DEC_IDLE)
            cmd_r <= wd;
      end
   end

   // first write holds the target address of a two-cycle setup operation
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cmd_addr_r <= '0;
         sub_r      <= 16'h0000;
         total_r    <= 10'd0;
      end else if (acc) begin
         if (st_r == DEC_IDLE)
            cmd_addr_r <= wr_addr_i;
         if (st_r == DEC_EFI_SUB)
            sub_r <= wr_data_i;
         if (st_r == DEC_BUF_COUNT || st_r == DEC_EFI_COUNT)
            total_r <= wr_data_i[9:0];
      end
   end

   // read state, status error bits, configuration
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         read_state_o              <= RD_ARRAY;
         read_cfg_o                <= `RCFG_RESET;
         status_program_fail_bit_o <= 1'b0;
         status_erase_fail_bit_o   <= 1'b0;
      end else begin
         if (rd_set)
            read_state_o <= rd_val;
         if (set_cfg)
            read_cfg_o <= wr_addr_i[`CFG_MSB:`CFG_LSB];
         if (acc && st_r == DEC_IDLE && wd == `CMD_CLEAR_STATUS) begin
            status_program_fail_bit_o <= 1'b0;
            status_erase_fail_bit_o   <= 1'b0;
         end
         if (seq_err) begin
            status_program_fail_bit_o <= 1'b1;
            status_erase_fail_bit_o   <= 1'b1;
         end
      end
   end

   // engine activity; reset aborts whatever runs
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         busy_o      <= 1'b0;
         suspended_o <= 1'b0;
      end else begin
         if (op_done_i)
            busy_o <= 1'b0;
         if (start_op)
            busy_o <= 1'b1;
         if (push && push_code == OP_SUSPEND)
            suspended_o <= 1'b1;
         if (push && push_code == OP_RESUME)
            suspended_o <= 1'b0;
      end
   end

   // two-entry operation buffer; head sits in slot 0 so outputs are flops
   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop)
         cnt_nxt = cnt_r + 2'd1;
      else if (pop && !push)
         cnt_nxt = cnt_r - 2'd1;
      slot = pop ? 1'b0 : cnt_r[0];
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_r      <= 2'd0;
         op_valid_o <= 1'b0;
         wr_ready_o <= 1'b1;
      end else begin
         cnt_r      <= cnt_nxt;
         op_valid_o <= cnt_nxt != 2'd0;
         wr_ready_o <= cnt_nxt < 2'd2;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 2; i++) begin
            mem_code[i] <= OP_WORD_PROG;
            mem_addr[i] <= '0;
            mem_data[i] <= 16'h0000;
         end
      end else begin
         if (pop) begin
            mem_code[0] <= mem_code[1];
            mem_addr[0] <= mem_addr[1];
            mem_data[0] <= mem_data[1];
         end
         if (push) begin
            mem_code[slot] <= push_code;
            // one-cycle commands carry their own address, not the last setup's
            mem_addr[slot] <= st_r == DEC_SETUP2 ? cmd_addr_r : wr_addr_i;
            mem_data[slot] <= push_data;
         end
      end
   end

   assign op_code_o = mem_code[0];
   assign op_addr_o = mem_addr[0];
   assign op_data_o = mem_data[0];

   // address pin low is transparent, rising edge holds the last address
   always_ff @(posedge sys_clk_i) begin
      if (rst_i)
         addr_hold_r <= '0;
      else if (!address_valid_pin_n_i)
         addr_hold_r <= rd_addr_i;
   end

   assign rd_addr_eff = address_valid_pin_n_i ? addr_hold_r : rd_addr_i;
   assign page_hit    = page_ok_r && page_mode_o && read_state_o == RD_ARRAY
                        && rd_addr_eff[`ADDR_MSB:5] == page_base_r;

   // page buffer: sense once per page, low bits pick the word
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sense_o      <= 1'b0;
         sense_addr_o <= '0;
         word_sel_o   <= 4'h0;
         page_base_r  <= '0;
         page_ok_r    <= 1'b0;
         page_mode_o  <= 1'b1;
         wait_o       <= ~RCFG_DEFAULT[`RCFG_WAIT_POL_BIT];
      end else begin
         page_mode_o <= read_cfg_o[`RCFG_ASYNC_BIT];
         wait_o      <= ~read_cfg_o[`RCFG_WAIT_POL_BIT];
         sense_o     <= rd_req_i && !page_hit;
         if (acc || set_cfg)
            page_ok_r <= 1'b0; // writes may change the array
         if (rd_req_i) begin
            word_sel_o <= rd_addr_eff[`PAGE_MSB:`PAGE_LSB];
            if (!page_hit) begin
               sense_addr_o <= rd_addr_eff;
               page_base_r  <= rd_addr_eff[`ADDR_MSB:5];
               page_ok_r    <= page_mode_o && read_state_o == RD_ARRAY;
            end
         end
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_suspend;
      acc && st_r == DEC_IDLE && wd == `CMD_SUSPEND && busy_o && !suspended_o;
   endsequence
   sequence s_bad_erase;
      acc && st_r == DEC_SETUP2 && cmd_r == `CMD_ERASE && wd != `CMD_CONFIRM;
   endsequence
   sequence s_cfg_write;
      acc && st_r == DEC_SETUP2 && cmd_r == `CMD_LOCK_SETUP && wd == `CMD_SET_CONFIG;
   endsequence

   property p_reset_defaults;
      @(posedge sys_clk_i) disable iff (1'b0)
         rst_i |=> read_state_o == RD_ARRAY && !busy_o && !suspended_o;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");
   property p_suspend;
      s_suspend |=> suspended_o ##0 op_valid_o;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend not taken");
   property p_read_id;
      acc && st_r == DEC_IDLE && wd == `CMD_READ_ID |=> read_state_o == RD_ID;
   endproperty
   a_read_id: assert property (p_read_id) else $error("identifier read not selected");
   property p_seq_error;
      s_bad_erase |=> status_program_fail_bit_o && status_erase_fail_bit_o
                      && read_state_o == RD_STATUS && st_r == DEC_IDLE;
   endproperty
   a_seq_error: assert property (p_seq_error) else $error("sequence error not flagged");
   property p_cfg_load;
      s_cfg_write |=> read_cfg_o == $past(wr_addr_i[`CFG_MSB:`CFG_LSB]) ##1
                      page_mode_o == read_cfg_o[`RCFG_ASYNC_BIT];
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("configuration not loaded");
   property p_wait_level;
      ##1 wait_o == !$past(read_cfg_o[`RCFG_WAIT_POL_BIT]);
   endproperty
   a_wait_level: assert property (p_wait_level) else $error("wait not inactive");
   property p_page_hit;
      rd_req_i && page_hit |=> !sense_o && word_sel_o == $past(rd_addr_eff[4:1]);
   endproperty
   a_page_hit: assert property (p_page_hit) else $error("page hit re-sensed");
   property p_no_page_nonarray;
      rd_req_i && read_state_o != RD_ARRAY |=> sense_o;
   endproperty
   a_no_page_nonarray: assert property (p_no_page_nonarray) else $error("page used off array");
   property p_word_prog;
      acc && st_r == DEC_SETUP2 && cmd_r == `CMD_WORD_PROG |=> op_valid_o && busy_o;
   endproperty
   a_word_prog: assert property (p_word_prog) else $error("word program not issued");
   property p_efi_data;
      acc && st_r == DEC_EFI_DATA |=> $stable(read_state_o) && !status_erase_fail_bit_o
                                      || $past(status_erase_fail_bit_o);
   endproperty
   a_efi_data: assert property (p_efi_data) else $error("data word decoded as command");
endmodule
`default_nettype wire

// ### verif/op_engine_model.sv
// Purpose: algorithm engine stand-in that drains the operation stream
// Assumes: done pulses three cycles after each operation is taken
// Notes:   stall_i blocks taking, hold_i blocks completion
`timescale 1ns/1ns
`default_nettype none
module op_engine_model (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // operation stream
   input  wire logic op_valid_i,
   input  wire logic stall_i,
   input  wire logic hold_i,
   output logic      op_ready_o,
   output logic      op_done_o
);
   logic [1:0] left_r;
   // random gaps so the buffer sees uneven draining
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) op_ready_o <= 1'b0;
      else op_ready_o <= ($urandom_range(3) != 0) && !stall_i;
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) left_r <= 2'd0;
      else if (op_valid_i && op_ready_o) left_r <= 2'd3;
      else if (left_r > 2'd1 || (left_r == 2'd1 && !hold_i)) left_r <= left_r - 2'd1;
   end
   assign op_done_o = (left_r == 2'd1) && !hold_i;
endmodule
`default_nettype wire

// ### verif/nor_flash_command_and_read_mode_ctrl_tb.sv
// Purpose: self-checking bench for the command and read-mode controller
// Assumes: engine model drains operations with random gaps
// Notes:   expected operations queue up as each command is written
`include "nor_cmd_map.svh"
`timescale 1ns/1ns
`default_nettype none
module nor_flash_command_and_read_mode_ctrl_tb;
   import nor_cmd_pkg::*;
   typedef struct { op_t c; logic [26:1] a; logic [15:0] d; bit k; } exp_t;
   logic clk, rst, wr_valid, wr_ready, op_valid, op_ready, op_done, rd_req;
   logic address_valid_pin_n, sense, wait_s, page, busy, susp, pf, ef, stall, hold;
   logic [26:1] wr_addr, op_addr, rd_addr, sense_addr, a, b, p;
   logic [15:0] wr_data, op_data, rcfg, d, v;
   logic [3:0] word_sel;
   op_t op_code;
   rd_state_t rstate;
   int fail_count, n_tests, cyc;
   exp_t q[$];
   logic [7:0] rc [4] = '{`CMD_READ_ID, `CMD_READ_QUERY, `CMD_READ_STATUS, `CMD_READ_ARRAY};
   rd_state_t rs [4] = '{RD_ID, RD_QUERY, RD_STATUS, RD_ARRAY};
   logic [7:0] f1 [5] = '{`CMD_ERASE, `CMD_BLANK_CHECK, 8'h60, 8'h60, 8'h60};
   logic [7:0] f2 [5] = '{`CMD_CONFIRM, `CMD_CONFIRM, `CMD_LOCK, `CMD_CONFIRM, `CMD_LOCK_DOWN};
   op_t fo [5] = '{OP_ERASE, OP_BLANK, OP_LOCK, OP_UNLOCK, OP_LOCK_DOWN};
   logic [7:0] s1 [3] = '{`CMD_ERASE, `CMD_LOCK_SETUP, `CMD_BUF_PROG};
   logic [15:0] s2 [3] = '{16'h00ff, 16'h0055, 16'h0200};

   nor_cmd_ctrl dut (.sys_clk_i(clk), .rst_i(rst), .wr_valid_i(wr_valid), .wr_addr_i(wr_addr),
      .wr_data_i(wr_data), .wr_ready_o(wr_ready), .op_valid_o(op_valid), .op_ready_i(op_ready),
      .op_code_o(op_code), .op_addr_o(op_addr), .op_data_o(op_data), .op_done_i(op_done),
      .rd_req_i(rd_req), .rd_addr_i(rd_addr), .address_valid_pin_n_i(address_valid_pin_n),
      .sense_o(sense), .sense_addr_o(sense_addr), .word_sel_o(word_sel), .wait_o(wait_s),
      .read_state_o(rstate), .read_cfg_o(rcfg), .page_mode_o(page), .busy_o(busy),
      .suspended_o(susp), .status_program_fail_bit_o(pf), .status_erase_fail_bit_o(ef));
   op_engine_model eng (.sys_clk_i(clk), .rst_i(rst), .op_valid_i(op_valid), .stall_i(stall),
      .hold_i(hold), .op_ready_o(op_ready), .op_done_o(op_done));

   always #5 clk = ~clk;

   task automatic close_out();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_op(input exp_t e);
      chk("op_code", 26'(e.c), 26'(op_code));
      chk("op_addr", e.a, op_addr);
      if (e.k) chk("op_data", 26'(e.d), 26'(op_data));
   endtask
   function automatic void ex(op_t c, logic [26:1] ad, logic [15:0] dd, bit k);
      q.push_back('{c, ad, dd, k});
   endfunction
   // holds the cycle up until ready is sampled high
   task automatic wr(input logic [26:1] ad, input logic [15:0] dd);
      wr_valid <= 1'b1;
      wr_addr <= ad;
      wr_data <= dd;
      @(posedge clk);
      while (wr_ready !== 1'b1) @(posedge clk);
   endtask
   task automatic idle();
      wr_valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic two(input logic [26:1] ad, input logic [7:0] x, input logic [7:0] y);
      wr(ad, {8'h00, x});
      wr(ad, {8'h00, y});
      idle();
   endtask
   task automatic rd(input logic [26:1] ad, input logic s);
      rd_req <= 1'b1;
      rd_addr <= ad;
      @(posedge clk);
      rd_req <= 1'b0;
      #1;
      chk("sense", 26'(s), 26'(sense));
      chk("word_sel", 26'(ad[4:1]), 26'(word_sel));
      if (s) chk("sense_addr", ad, sense_addr);
   endtask
   task automatic wait_q();
      for (int k = 0; k < 300 && q.size() > 0; k++) @(posedge clk);
      repeat (6) @(posedge clk);
      #1;
      chk("drain", 26'd0, 26'(q.size()));
   endtask
   task automatic word(input op_t c, input logic [7:0] x);
      a = 26'($urandom);
      d = 16'($urandom);
      ex(c, a, d, 1'b1);
      wr(a, {8'h00, x});
      wr(a, d);
      idle();
   endtask

   always @(posedge clk) begin
      if (!rst && op_valid === 1'b1 && op_ready === 1'b1) begin
         if (q.size() == 0) chk("op_extra", 26'd0, 26'd1);
         else chk_op(q.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      wr_valid = 1'b0;
      wr_addr = '0;
      wr_data = '0;
      rd_req = 1'b0;
      rd_addr = '0;
      address_valid_pin_n = 1'b0;
      stall = 1'b0;
      hold = 1'b0;
      void'($urandom(32'hf6730e0e));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("read_state", 26'(RD_ARRAY), 26'(rstate));
      chk("read_cfg", 26'(`RCFG_RESET), 26'(rcfg));
      chk("page_mode", 26'd1, 26'(page));
      chk("wait", 26'd1, 26'(wait_s));
      for (int i = 0; i < 4; i++) begin
         wr(26'($urandom), {8'h00, rc[i]});
         idle();
         chk("read_state", 26'(rs[i]), 26'(rstate));
      end
      p = 26'($urandom);
      p[4:1] = 4'h0;
      // present the address while the pin is low so the rising edge latches it
      rd_addr <= p + 26'd5;
      @(posedge clk);
      address_valid_pin_n <= 1'b1;
      rd(p + 26'd5, 1'b1);
      address_valid_pin_n <= 1'b0;
      rd(p + 26'd12, 1'b0);
      wr(p, {8'h00, `CMD_READ_ID});
      idle();
      rd(p, 1'b1);
      rd(p, 1'b1);
      // sync bursts never issued; the loaded setting clears the async bit 15, so page mode turns off
      v = 16'($urandom) & 16'h7fff | 16'h0400;
      a = 26'($urandom);
      a[16:1] = v;
      two(a, `CMD_LOCK_SETUP, `CMD_SET_CONFIG);
      chk("read_cfg", 26'(v), 26'(rcfg));
      chk("page_mode", 26'd0, 26'(page));
      chk("wait", 26'd0, 26'(wait_s));
      chk("read_state", 26'(RD_ARRAY), 26'(rstate));
      rd(p, 1'b1);
      rd(p, 1'b1);
      a[16:1] = `RCFG_RESET;
      two(a, `CMD_LOCK_SETUP, `CMD_SET_CONFIG);
      for (int i = 0; i < 5; i++) begin
         a = 26'($urandom);
         ex(fo[i], a, 16'h0000, 1'b0);
         two(a, f1[i], f2[i]);
      end
      word(OP_WORD_PROG, `CMD_WORD_PROG);
      word(OP_OTP, `CMD_OTP_PROG);
      chk("read_state", 26'(RD_STATUS), 26'(rstate));
      for (int i = 0; i < 3; i++) begin
         wr(a, {8'h00, s1[i]});
         wr(a, s2[i]);
         idle();
         chk("prog_fail", 26'd1, 26'(pf));
         chk("erase_fail", 26'd1, 26'(ef));
         chk("read_state", 26'(RD_STATUS), 26'(rstate));
         wr(a, {8'h00, `CMD_CLEAR_STATUS});
         idle();
         chk("erase_fail", 26'd0, 26'(ef));
      end
      a = 26'($urandom);
      wr(a, {8'h00, `CMD_BUF_PROG});
      wr(a, 16'd2);
      for (int j = 0; j < 3; j++) begin
         b = 26'($urandom);
         d = 16'($urandom);
         ex(OP_BUF_DATA, b, d, 1'b1);
         wr(b, d);
      end
      ex(OP_BUF_PROG, a, 16'h0000, 1'b0);
      wr(a, {8'h00, `CMD_CONFIRM});
      idle();
      chk("prog_fail", 26'd0, 26'(pf));
      d = 16'($urandom_range(255));
      wr(a, {8'h00, `CMD_EXT_FUNC});
      wr(a, d);
      wr(a, 16'd1);
      ex(OP_EFI_DATA, a, 16'h00ff, 1'b1);
      wr(a, 16'h00ff);
      ex(OP_EFI_DATA, a, 16'h0090, 1'b1);
      wr(a, 16'h0090);
      ex(OP_EFI, a, d, 1'b1);
      wr(a, {8'h00, `CMD_CONFIRM});
      idle();
      chk("read_state", 26'(RD_STATUS), 26'(rstate));
      wait_q();
      hold <= 1'b1;
      word(OP_WORD_PROG, `CMD_WORD_PROG);
      wait_q();
      chk("busy", 26'd1, 26'(busy));
      ex(OP_SUSPEND, a, 16'h0000, 1'b0);
      two(a, `CMD_SUSPEND, `CMD_SUSPEND);
      chk("suspended", 26'd1, 26'(susp));
      ex(OP_RESUME, a, 16'h0000, 1'b0);
      wr(a, {8'h00, `CMD_CONFIRM});
      idle();
      chk("suspended", 26'd0, 26'(susp));
      hold <= 1'b0;
      wait_q();
      stall <= 1'b1;
      word(OP_WORD_PROG, `CMD_WORD_PROG);
      word(OP_WORD_PROG, `CMD_WORD_PROG);
      chk("wr_ready", 26'd0, 26'(wr_ready));
      stall <= 1'b0;
      wait_q();
      hold <= 1'b1;
      ex(OP_FACTORY, a, 16'h0000, 1'b0);
      two(a, `CMD_FACTORY_PROG, `CMD_CONFIRM);
      for (int j = 0; j < 2; j++) begin
         d = 16'($urandom);
         ex(OP_FACT_DATA, a, d, 1'b1);
         wr(a, d);
      end
      idle();
      wait_q();
      hold <= 1'b0;
      repeat (8) @(posedge clk);
      wr(a, {8'h00, `CMD_READ_ARRAY});
      idle();
      chk("read_state", 26'(RD_ARRAY), 26'(rstate));
      hold <= 1'b1;
      word(OP_WORD_PROG, `CMD_WORD_PROG);
      wait_q();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      hold <= 1'b0;
      @(posedge clk);
      #1;
      chk("busy", 26'd0, 26'(busy));
      chk("op_valid", 26'd0, 26'(op_valid));
      chk("read_state", 26'(RD_STATUS) ^ 26'(RD_STATUS) | 26'(RD_ARRAY), 26'(rstate));
      close_out();
   end
endmodule
`default_nettype wire
